// ===== dv/proc_bus_model.sv
module proc_bus_model (
   input  wire logic        ref_clk,        // Bus clock.
   output logic      [7:0]  chip_select_n,  // Selects, active low.
   output logic      [0:31] proc_addr,      // Buffered address.
   output logic             bus_wr,         // Write strobe.
   output logic             bus_rd,         // Read strobe.
   output logic      [31:0] wr_data,        // Write data.
   output logic             rstconf_n       // Configuration word read.
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      chip_select_n = 8'hFF;
      proc_addr = 32'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      wr_data = 32'hFFFFFFFF;
      rstconf_n = 1'b1;
   end

   // Write data flips when idle so a stale value can never pass for a fresh one.
   task automatic park();
      @(negedge ref_clk);
      chip_select_n = 8'hFF;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      rstconf_n = 1'b1;
      wr_data = ~wr_data;
   endtask : park

   // Register cycles run from select 1, never from DRAM code space.
   task automatic reg_cycle(input logic wr, input logic sel, input logic [31:0] data);
      @(negedge ref_clk);
      chip_select_n = 8'hFD;
      proc_addr = {29'h0, sel, 2'h0};
      bus_wr = wr;
      bus_rd = !wr;
      wr_data = data;
      park();
   endtask : reg_cycle

   // The memory machine asserts the region select with its address.
   task automatic select(input int cs, input logic [0:31] addr);
      @(negedge ref_clk);
      chip_select_n = ~(8'h01 << cs);
      proc_addr = addr;
   endtask : select

   // Dual-bank module: bank two starts half the volume above the base, or a
   // quarter of it in half-word mode, so the upper half of each bank goes unused.
   function automatic int dram_bank(input logic [31:0] addr, input logic [1:0] size_code,
                                    input logic half);
      logic [31:0] span;
      span = (32'h0020_0000 << size_code) >> half;
      return (size_code[0] && ((addr % (span << 1)) >= span)) ? 3 : 2;
   endfunction : dram_bank

   // The generator clock is modelled by the bus clock; the low-power divider
   // never slows it, so refresh keeps its pace in any power mode.
   localparam int BEATS     = 4;    // Beats per burst here; the machine allows 16.
   localparam int BURST_CLK = 21;   // Clocks per four-beat burst.
   localparam int PRESCALE  = 16;   // Shared prescaler, legal from 2 to 64.

   function automatic int refresh_divider(input int period_ns, input int rows,
                                          input int t_gen_ns, input int banks);
      return (period_ns * BEATS) / (rows * t_gen_ns * PRESCALE * banks);
   endfunction : refresh_divider

   // One burst on both bank selects once prescaler and divider run out; the
   // selects stay low at return so that the caller can look at the strobes.
   task automatic refresh(input int divider);
      repeat (PRESCALE * divider) @(negedge ref_clk);
      chip_select_n = 8'hF3;
      repeat (BURST_CLK - 1) @(negedge ref_clk);
   endtask : refresh

   task automatic config_read();
      @(negedge ref_clk);
      chip_select_n = 8'hFF;
      rstconf_n = 1'b0;
   endtask : config_read
endmodule : proc_bus_model

// ===== dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {string name; logic [31:0] val;} note_t;
   logic        ref_clk, reset_n, por_n, bus_wr, bus_rd, rstconf_n, dram_delay_pd;
   logic [7:0]  chip_select_n;
   logic [0:31] proc_addr;
   logic [31:0] wr_data, rd_data, rnd;
   logic [1:0]  dram_size_pd;
   logic        xcvr_enable_n, xcvr_low_enable_n, mem_word_lsb;
   logic        flash_enable_n, dram_enable_n, sync_dram_enable, ctrl_block_off;
   logic [10:0] dram_addr;
   logic [3:0]  dram_ras_n;
   logic [4:0]  cfg [3] = '{5'h11, 5'h14, 5'h00};
   note_t       notes[$];
   event        sample_ev;
   int          n_mismatch, n_compared;

   proc_bus_model bus (.ref_clk(ref_clk), .chip_select_n(chip_select_n),
      .proc_addr(proc_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .wr_data(wr_data),
      .rstconf_n(rstconf_n));
   board_glue dut (.ref_clk(ref_clk), .reset_n(reset_n), .por_n(por_n),
      .chip_select_n(chip_select_n), .proc_addr(proc_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .wr_data(wr_data), .rstconf_n(rstconf_n),
      .dram_size_pd(dram_size_pd), .dram_delay_pd(dram_delay_pd),
      .xcvr_enable_n(xcvr_enable_n), .xcvr_low_enable_n(xcvr_low_enable_n),
      .dram_addr(dram_addr), .dram_ras_n(dram_ras_n), .mem_word_lsb(mem_word_lsb),
      .rd_data(rd_data), .flash_enable_n(flash_enable_n), .dram_enable_n(dram_enable_n),
      .sync_dram_enable(sync_dram_enable), .ctrl_block_off(ctrl_block_off));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [10:0] exp_addr(input logic [0:31] a, input logic h, input logic d);
      logic [10:0] e;
      for (int i = 0; i < 9; i++) e[i] = a[29 - i];
      e[9] = (h && !d) ? a[30] : a[20];
      e[10] = (h && d) ? a[30] : a[19];
      return e;
   endfunction : exp_addr

   function automatic logic [31:0] seen_of(input string n);
      case (n)
         "xcvr":  return 32'(xcvr_enable_n);
         "low":   return 32'(xcvr_low_enable_n);
         "ras":   return 32'(dram_ras_n);
         "addr":  return 32'(dram_addr);
         "lsb":   return 32'(mem_word_lsb);
         "rd":    return rd_data;
         "flash": return 32'(flash_enable_n);
         "dram":  return 32'(dram_enable_n);
         "sdram": return 32'(sync_dram_enable);
         "block": return 32'(ctrl_block_off);
         default: return 32'hXXXXXXXX;
      endcase
   endfunction : seen_of

   task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic note(input string n, input logic [31:0] v);
      note_t t;
      t.name = n;
      t.val = v;
      notes.push_back(t);
   endtask : note

   // Outputs are looked at 1 ns after the falling edge, once inputs have settled.
   task automatic sample();
      #1;
      -> sample_ev;
      #1;
   endtask : sample

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   initial begin
      note_t t;
      forever begin
         @(sample_ev);
         while (notes.size() > 0) begin
            t = notes.pop_front();
            check(t.name, t.val, seen_of(t.name));
         end
      end
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      results();
   end

   initial begin
      reset_n = 1'b0;
      por_n = 1'b0;
      dram_size_pd = 2'h0;
      dram_delay_pd = 1'b0;
      rnd = 32'h39;
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      por_n = 1'b1;
      note("flash", 32'h0);
      note("dram", 32'h0);
      note("sdram", 32'h1);
      note("block", 32'h0);
      sample();
      $display("test reset done");
      for (int cs = 0; cs < 8; cs++) begin
         bus.select(cs, 32'h0);
         note("xcvr", 32'(cs > 3));
         note("ras", (cs == 2) ? 32'hC : (cs == 3) ? 32'h3 : 32'hF);
         sample();
      end
      bus.config_read();
      note("xcvr", 32'h0);
      sample();
      bus.park();
      note("xcvr", 32'h1);
      sample();
      $display("test select map done");
      for (int k = 0; k < 3; k++) begin
         bus.reg_cycle(1'b1, 1'b0, {27'h0, cfg[k]});
         note("flash", 32'(cfg[k][0]));
         note("dram", 32'(cfg[k][2]));
         note("sdram", 32'(cfg[k][4]));
         sample();
         bus.select(0, 32'h0);
         note("xcvr", 32'(cfg[k][0]));
         sample();
         bus.select(2, 32'h0);
         note("xcvr", 32'(cfg[k][2]));
         note("ras", cfg[k][2] ? 32'hF : 32'hC);
         sample();
      end
      $display("test enables done");
      for (int h = 0; h < 2; h++) begin
         bus.reg_cycle(1'b1, 1'b0, 32'h10 | 32'(h << 3));
         for (int j = 0; j < 16; j++) begin
            @(negedge ref_clk);
            dram_size_pd = j[1:0];
            rnd = lfsr(rnd);
            bus.select(bus.dram_bank(rnd, j[1:0], h[0]), rnd);
            note("addr", 32'(exp_addr(rnd, h[0], j[1])));
            note("lsb", 32'(h ? rnd[1] : rnd[2]));
            note("low", 32'(h));
            note("xcvr", 32'h0);
            sample();
         end
      end
      $display("test address mux done");
      for (int j = 0; j < 8; j++) begin
         @(negedge ref_clk);
         dram_size_pd = j[1:0];
         dram_delay_pd = j[2];
         bus.reg_cycle(1'b1, 1'b1, 32'hFFFFFFFF);
         bus.reg_cycle(1'b0, 1'b1, 32'h0);
         note("rd", 32'(j));
         sample();
      end
      $display("test status done");
      bus.refresh(bus.refresh_divider(16000000, 1024, 20, 2));
      note("ras", 32'h0);
      sample();
      bus.park();
      $display("test refresh done");
      bus.reg_cycle(1'b1, 1'b0, 32'h12);
      bus.select(1, 32'h0);
      note("block", 32'h1);
      note("xcvr", 32'h1);
      sample();
      bus.reg_cycle(1'b1, 1'b0, 32'h11);
      note("flash", 32'h0);
      sample();
      @(negedge ref_clk);
      reset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b1;
      note("block", 32'h1);
      sample();
      @(negedge ref_clk);
      por_n = 1'b0;
      reset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      por_n = 1'b1;
      reset_n = 1'b1;
      note("block", 32'h0);
      sample();
      bus.reg_cycle(1'b1, 1'b0, 32'h11);
      note("flash", 32'h1);
      sample();
      $display("test block removal done");
      results();
   end
endmodule : testbench

// ===== rtl/board_glue.sv
module board_glue (
   input  logic        ref_clk,            // Processor bus clock.
   input  logic        reset_n,            // Hard reset, async, active low.
   input  logic        por_n,              // Power-on reset, async, active low.
   input  logic [7:0]  chip_select_n,      // Processor chip selects, active low.
   input  logic [0:31] proc_addr,          // Buffered processor address.
   input  logic        bus_wr,             // Write strobe of the current access.
   input  logic        bus_rd,             // Read strobe of the current access.
   input  logic [31:0] wr_data,            // Write data of the current access.
   input  logic        rstconf_n,          // Configuration word being read.
   input  logic [1:0]  dram_size_pd,       // DRAM presence-detect size code.
   input  logic        dram_delay_pd,      // DRAM presence-detect delay code.
   output logic        xcvr_enable_n,      // Data transceiver enable.
   output logic        xcvr_low_enable_n,  // Lower lane transceiver enable.
   output logic [10:0] dram_addr,          // Multiplexed DRAM address.
   output logic [3:0]  dram_ras_n,         // DRAM row strobes, two per bank.
   output logic        mem_word_lsb,       // Least significant word line.
   output logic [31:0] rd_data,            // Register read data.
   output logic        flash_enable_n,     // Flash module disabled when high.
   output logic        dram_enable_n,      // DRAM module disabled when high.
   output logic        sync_dram_enable,   // SDRAM module enabled when high.
   output logic        ctrl_block_off      // Register block removed.
);

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   function automatic logic region_open(input logic cs_n, input logic en);
      return !cs_n && en;
   endfunction : region_open

   logic                       flash_en_n_ff;
   logic                       dram_en_n_ff;
   logic                       half_word_ff;
   logic                       sdram_en_ff;
   logic                       ctrl_dis_ff;
   logic [glue_pkg::R2_W-1:0]  status_ff;
   logic [31:0]                rd_data_ff;
   logic                       nxt_flash_en_n;
   logic                       nxt_dram_en_n;
   logic                       nxt_half_word;
   logic                       nxt_sdram_en;
   logic                       nxt_ctrl_dis;
   logic [glue_pkg::R2_W-1:0]  nxt_status;
   logic [31:0]                nxt_rd_data;
   logic                       ctrl_hit;
   logic                       reg_one_wr;
   logic                       reg_rd;
   logic                       dram_hit;
   logic                       board_hit;
   logic [glue_pkg::R1_W-1:0]  reg_one_val;

   // ------------------------------------------------------------------
   // Register block access
   // ------------------------------------------------------------------
   // Once the block is removed, its select belongs to off-board logic and
   // neither writes nor reads may touch the local registers.
   assign ctrl_hit   = region_open(chip_select_n[glue_pkg::CS_CTRL], !ctrl_dis_ff);
   assign reg_one_wr = ctrl_hit && bus_wr && !proc_addr[glue_pkg::REG_SEL_BIT];
   assign reg_rd     = ctrl_hit && bus_rd;

   always_comb begin
      reg_one_val                         = '0;
      reg_one_val[glue_pkg::R1_FLASH_EN_N] = flash_en_n_ff;
      reg_one_val[glue_pkg::R1_CTRL_DIS]   = ctrl_dis_ff;
      reg_one_val[glue_pkg::R1_DRAM_EN_N]  = dram_en_n_ff;
      reg_one_val[glue_pkg::R1_HALF_WORD]  = half_word_ff;
      reg_one_val[glue_pkg::R1_SDRAM_EN]   = sdram_en_ff;
   end

   // ------------------------------------------------------------------
   // Control register one, loaded with R1_RST by hard reset
   // ------------------------------------------------------------------
   always_comb begin
      nxt_flash_en_n = flash_en_n_ff;
      nxt_dram_en_n  = dram_en_n_ff;
      nxt_half_word  = half_word_ff;
      nxt_sdram_en   = sdram_en_ff;
      if (reg_one_wr) begin
         nxt_flash_en_n = wr_data[glue_pkg::R1_FLASH_EN_N];
         nxt_dram_en_n  = wr_data[glue_pkg::R1_DRAM_EN_N];
         nxt_half_word  = wr_data[glue_pkg::R1_HALF_WORD];
         nxt_sdram_en   = wr_data[glue_pkg::R1_SDRAM_EN];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flash_en_n_ff <= glue_pkg::R1_RST[glue_pkg::R1_FLASH_EN_N];
         dram_en_n_ff  <= glue_pkg::R1_RST[glue_pkg::R1_DRAM_EN_N];
         half_word_ff  <= glue_pkg::R1_RST[glue_pkg::R1_HALF_WORD];
         sdram_en_ff   <= glue_pkg::R1_RST[glue_pkg::R1_SDRAM_EN];
      end else begin
         flash_en_n_ff <= nxt_flash_en_n;
         dram_en_n_ff  <= nxt_dram_en_n;
         half_word_ff  <= nxt_half_word;
         sdram_en_ff   <= nxt_sdram_en;
      end
   end

   // ------------------------------------------------------------------
   // Register block removal, cleared only at power-on
   // ------------------------------------------------------------------
   // Hard reset must not bring the block back: an off-board device may
   // already own the select, and a sudden local answer would collide.
   always_comb begin
      nxt_ctrl_dis = ctrl_dis_ff | (reg_one_wr & wr_data[glue_pkg::R1_CTRL_DIS]);
   end

   always_ff @(posedge ref_clk or negedge por_n) begin
      if (!por_n) begin
         ctrl_dis_ff <= glue_pkg::R1_RST[glue_pkg::R1_CTRL_DIS];
      end else begin
         ctrl_dis_ff <= nxt_ctrl_dis;
      end
   end

   // ------------------------------------------------------------------
   // Status register two and read data
   // ------------------------------------------------------------------
   always_comb begin
      nxt_status                                                = status_ff;
      nxt_status[glue_pkg::R2_SIZE_MSB:glue_pkg::R2_SIZE_LSB] = dram_size_pd;
      nxt_status[glue_pkg::R2_DELAY]                            = dram_delay_pd;
      nxt_rd_data = rd_data_ff;
      if (reg_rd) begin
         if (proc_addr[glue_pkg::REG_SEL_BIT]) begin
            nxt_rd_data = 32'(status_ff);
         end else begin
            nxt_rd_data = 32'(reg_one_val);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_ff  <= glue_pkg::R2_RST;
         rd_data_ff <= 32'h0000_0000;
      end else begin
         status_ff  <= nxt_status;
         rd_data_ff <= nxt_rd_data;
      end
   end

   // ------------------------------------------------------------------
   // Transceiver decode
   // ------------------------------------------------------------------
   // Pure gates from the live selects keep the enable inside the same bus
   // cycle, so no wait state is needed. The SDRAM select is left out on
   // purpose: that memory hangs on the processor bus itself.
   always_comb begin
      dram_hit  = region_open(chip_select_n[glue_pkg::CS_DRAM1], !dram_en_n_ff) |
                  region_open(chip_select_n[glue_pkg::CS_DRAM2], !dram_en_n_ff);
      board_hit = region_open(chip_select_n[glue_pkg::CS_FLASH], !flash_en_n_ff) |
                  region_open(chip_select_n[glue_pkg::CS_CTRL], !ctrl_dis_ff) |
                  dram_hit;
      xcvr_enable_n     = !(board_hit || !rstconf_n);
      xcvr_low_enable_n = xcvr_enable_n | (dram_hit & half_word_ff);
   end

   // ------------------------------------------------------------------
   // DRAM address and strobe path
   // ------------------------------------------------------------------
   dram_side_if dif ();

   assign dif.half_word = half_word_ff;
   assign dif.deep_4m   = status_ff[glue_pkg::R2_SIZE_MSB];
   assign dif.dram_en_n = dram_en_n_ff;
   assign dif.bank_cs_n = chip_select_n[glue_pkg::CS_DRAM2:glue_pkg::CS_DRAM1];
   assign dif.addr      = proc_addr;

   dram_addr_mux u_mux (
      .dif (dif.mux)
   );

   assign dram_addr        = dif.dram_addr;
   assign dram_ras_n       = dif.ras_n;
   assign mem_word_lsb     = dif.word_lsb;
   assign rd_data          = rd_data_ff;
   assign flash_enable_n   = flash_en_n_ff;
   assign dram_enable_n    = dram_en_n_ff;
   assign sync_dram_enable = sdram_en_ff;
   assign ctrl_block_off   = ctrl_dis_ff;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (!reset_n);

   sequence s_status_read;
      reg_rd && proc_addr[glue_pkg::REG_SEL_BIT];
   endsequence

   sequence s_dram_write(logic v);
      reg_one_wr && (wr_data[glue_pkg::R1_DRAM_EN_N] == v);
   endsequence

   a_xcvr_flash_open: assert property (
      (!chip_select_n[glue_pkg::CS_FLASH] && !flash_en_n_ff) |-> !xcvr_enable_n)
      else $error("Transceivers closed on enabled flash access.");

   a_xcvr_idle_closed: assert property (
      (&chip_select_n && rstconf_n) |-> xcvr_enable_n)
      else $error("Transceivers open with no select.");

   a_xcvr_config_open: assert property (
      !rstconf_n |-> !xcvr_enable_n)
      else $error("Transceivers closed during configuration read.");

   a_xcvr_sdram_closed: assert property (
      (chip_select_n == 8'hEF && rstconf_n) |-> xcvr_enable_n)
      else $error("Transceivers opened for SDRAM access.");

   a_xcvr_off_region: assert property (
      (chip_select_n == 8'hFB && dram_en_n_ff && rstconf_n) |-> xcvr_enable_n)
      else $error("Transceivers opened for disabled DRAM.");

   a_ctrl_write_blocked: assert property (
      (ctrl_dis_ff && bus_wr && !chip_select_n[glue_pkg::CS_CTRL])
      |=> $stable(flash_en_n_ff) && $stable(dram_en_n_ff) && $stable(sdram_en_ff))
      else $error("Removed register block took a write.");

   a_ctrl_lockout_held: assert property (
      @(posedge ref_clk) disable iff (!por_n)
      ctrl_dis_ff |=> ctrl_dis_ff)
      else $error("Register block came back without power cycle.");

   a_status_report: assert property (
      s_status_read |=> rd_data == 32'($past(status_ff)))
      else $error("Status read does not show DRAM size and delay.");

   a_ras_fanout: assert property (
      (!chip_select_n[glue_pkg::CS_DRAM1] && !dram_en_n_ff)
      |-> (dram_ras_n[1:0] == 2'h0 && dram_ras_n[3:2] == {2{chip_select_n[3]}}))
      else $error("Bank strobe copies do not follow the select.");

   a_dram_enable_write: assert property (
      s_dram_write(1'b1) |=> dram_enable_n ##1 (dram_enable_n || $past(reg_one_wr)))
      else $error("DRAM enable write did not take effect.");

   a_low_lane_closed: assert property (
      (half_word_ff && !chip_select_n[glue_pkg::CS_DRAM1] && !dram_en_n_ff)
      |-> (xcvr_low_enable_n && !xcvr_enable_n))
      else $error("Lower lanes opened in half-word DRAM mode.");

   a_addr_fixed: assert property (
      (dram_addr[0] == proc_addr[29]) && (dram_addr[8] == proc_addr[21]))
      else $error("Fixed DRAM address line misrouted.");

   a_addr_switch_deep: assert property (
      (half_word_ff && status_ff[glue_pkg::R2_SIZE_MSB])
      |-> (dram_addr[10] == proc_addr[30] && dram_addr[9] == proc_addr[20]))
      else $error("Deep module half-word routing wrong.");

   a_addr_switch_wide: assert property (
      !half_word_ff |-> (dram_addr[10:9] == {proc_addr[19], proc_addr[20]}))
      else $error("Full-width DRAM routing wrong.");

   a_word_lsb: assert property (
      mem_word_lsb == (half_word_ff ? proc_addr[30] : proc_addr[29]))
      else $error("Word line does not match port width.");

   a_sdram_bit: assert property (
      (reg_one_wr && !wr_data[glue_pkg::R1_SDRAM_EN]) |=> !sync_dram_enable)
      else $error("SDRAM enable write ignored.");

   a_addr_switch_shallow: assert property (
      (half_word_ff && !status_ff[glue_pkg::R2_SIZE_MSB])
      |-> (dram_addr[9] == proc_addr[30]))
      else $error("Shallow module half-word routing wrong.");

   a_flash_bit: assert property (
      (reg_one_wr && wr_data[glue_pkg::R1_FLASH_EN_N]) |=> flash_enable_n)
      else $error("Flash disable write ignored.");

   a_xcvr_spare_closed: assert property (
      (&chip_select_n[4:0] && rstconf_n) |-> xcvr_enable_n)
      else $error("Transceivers opened for a spare select.");

endmodule : board_glue

// ===== rtl/dram_addr_mux.sv
module dram_addr_mux (
   dram_side_if.mux dif   // Control in, DRAM pins out.
);

   // ------------------------------------------------------------------
   // Fixed address lines
   // ------------------------------------------------------------------
   for (genvar i = 0; i < 9; i++) begin : g_fixed
      assign dif.dram_addr[i] = dif.addr[29-i];
   end

   // ------------------------------------------------------------------
   // Switched address lines
   // ------------------------------------------------------------------
   // Only two lines move with the port width, so addressing is not linear
   // across a width change; that is the price of a two-line multiplexer.
   assign dif.dram_addr[9]  = (dif.half_word && !dif.deep_4m) ?
                              dif.addr[30] : dif.addr[20];
   assign dif.dram_addr[10] = (dif.half_word && dif.deep_4m) ?
                              dif.addr[30] : dif.addr[19];
   assign dif.word_lsb      = dif.half_word ? dif.addr[30] : dif.addr[29];

   // ------------------------------------------------------------------
   // Row strobe fan-out
   // ------------------------------------------------------------------
   // Each bank select drives two copies to split the strobe load. A disabled
   // module never sees a strobe, so the select can serve off-board memory.
   for (genvar b = 0; b < 2; b++) begin : g_ras
      assign dif.ras_n[2*b]   = dif.bank_cs_n[b] | dif.dram_en_n;
      assign dif.ras_n[2*b+1] = dif.bank_cs_n[b] | dif.dram_en_n;
   end

endmodule : dram_addr_mux

// ===== rtl/dram_side_if.sv
interface dram_side_if;
   logic            half_word;  // Half-word DRAM mode.
   logic            deep_4m;    // Module rows are 4M deep.
   logic            dram_en_n;  // DRAM module disabled when high.
   logic [1:0]      bank_cs_n;  // Selects of banks one and two.
   logic [0:31]     addr;       // Buffered processor address.
   logic [10:0]     dram_addr;  // Multiplexed DRAM address.
   logic [3:0]      ras_n;      // Fanned-out row strobes.
   logic            word_lsb;   // Least significant word line.

   modport ctrl (
      output half_word, deep_4m, dram_en_n, bank_cs_n, addr,
      input  dram_addr, ras_n, word_lsb
   );

   modport mux (
      input  half_word, deep_4m, dram_en_n, bank_cs_n, addr,
      output dram_addr, ras_n, word_lsb
   );
endinterface : dram_side_if

// ===== rtl/glue_pkg.sv
package glue_pkg;

   // ------------------------------------------------------------------
   // Chip-select allocation
   // ------------------------------------------------------------------
   localparam int NUM_CS   = 8;
   localparam int CS_FLASH = 0;
   localparam int CS_CTRL  = 1;
   localparam int CS_DRAM1 = 2;
   localparam int CS_DRAM2 = 3;
   localparam int CS_SDRAM = 4;

   // ------------------------------------------------------------------
   // Control register one fields and reset value
   // ------------------------------------------------------------------
   localparam int          R1_W          = 5;
   localparam int          R1_FLASH_EN_N = 0;
   localparam int          R1_CTRL_DIS   = 1;
   localparam int          R1_DRAM_EN_N  = 2;
   localparam int          R1_HALF_WORD  = 3;
   localparam int          R1_SDRAM_EN   = 4;
   localparam logic [4:0]  R1_RST        = 5'h10;

   // ------------------------------------------------------------------
   // Status register two fields and reset value
   // ------------------------------------------------------------------
   localparam int          R2_W        = 3;
   localparam int          R2_SIZE_LSB = 0;
   localparam int          R2_SIZE_MSB = 1;
   localparam int          R2_DELAY    = 2;
   localparam logic [2:0]  R2_RST      = 3'h0;
   localparam logic [1:0]  SIZE_4M     = 2'h0;
   localparam logic [1:0]  SIZE_8M     = 2'h1;
   localparam logic [1:0]  SIZE_16M    = 2'h2;
   localparam logic [1:0]  SIZE_32M    = 2'h3;
   localparam logic        DELAY_60NS  = 1'h0;
   localparam logic        DELAY_70NS  = 1'h1;

   // ------------------------------------------------------------------
   // Register select inside the control/status region
   // ------------------------------------------------------------------
   localparam int          REG_SEL_BIT = 29;

endpackage : glue_pkg
